// file: inc/dpsp_pkg.sv
// ============================================================
// shared constants for the serial programming port
// ============================================================
package dpsp_pkg;

   // word layout: last bit in sits at bit 0 of the shift register
   localparam int WORD_W = 21; // bits kept per burst
   localparam int ADDR_W = 4; // trailing address field
   localparam int DATA_W = 17; // leading data field
   localparam int ADDR_LSB = 0; // address field position in the word
   localparam int DATA_LSB = 4; // data field position in the word

   // ============================================================
   // latch address codes
   // ============================================================
   localparam logic [3:0] ADDR_CTRL = 4'h0; // control and test word
   localparam logic [3:0] ADDR_MAIN_FB = 4'h1; // main loop feedback divider
   localparam logic [3:0] ADDR_MAIN_REF = 4'h2; // main loop reference divider
   localparam logic [3:0] ADDR_SECOND_FB = 4'h3; // second loop feedback divider
   localparam logic [3:0] ADDR_SECOND_REF = 4'h4; // second loop reference divider

   // ============================================================
   // control word fields (data field bit positions)
   // ============================================================
   localparam int CTL_TEST_HI = 16; // test bits, upper
   localparam int CTL_TEST_LO = 15; // test bits, lower
   localparam int CTL_LOCK_MAIN = 14; // lock_sel_main
   localparam int CTL_LOCK_SECOND = 13; // lock_sel_second
   localparam int CTL_RATIO_HI = 12; // pump_ratio_sel_hi
   localparam int CTL_RATIO_LO = 11; // pump_ratio_sel_lo
   localparam int CTL_SW_MAIN = 9; // main_loop_sw_shutdown
   localparam int CTL_SW_SECOND = 8; // second_loop_sw_shutdown

   // ============================================================
   // divider widths and reset values
   // ============================================================
   localparam int MAIN_FB_W = 17; // main feedback coefficient
   localparam int MAIN_REF_W = 11; // main reference coefficient
   localparam int SECOND_FB_W = 14; // second feedback coefficient
   localparam int SECOND_REF_W = 11; // second reference coefficient
   // both loops start switched off until software turns them on
   localparam logic [16:0] CTRL_RESET = 17'h00300;
   localparam logic [16:0] MAIN_FB_RESET = 17'h00200; // lowest legal ratio
   localparam logic [10:0] MAIN_REF_RESET = 11'h008;
   localparam logic [13:0] SECOND_FB_RESET = 14'h0040;
   localparam logic [10:0] SECOND_REF_RESET = 11'h008;

   // lock output source selection
   typedef enum logic [1:0] {
      LOCK_OFF = 2'b00,
      LOCK_SECOND = 2'b01,
      LOCK_MAIN = 2'b10,
      LOCK_BOTH = 2'b11
   } dpsp_lock_sel_t;

   // rising edge of a sampled level
   function automatic logic rise(input logic prev, input logic cur);
      rise = cur & ~prev;
   endfunction

endpackage

// file: core/dpsp_sync.sv
`timescale 1ns/1ps
// ============================================================
// two flop synchroniser for pin inputs
// ============================================================
module dpsp_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_q; // first stage, read only by the second
   logic [W-1:0] sync_q; // second stage

   // both stages freeze with the clock enable
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (clk_en_i) begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule // dpsp_sync

// file: core/dpsp_divider.sv
`timescale 1ns/1ps
// ============================================================
// programmable down counter with reload from its ratio latch
// ============================================================
module dpsp_divider #(
   parameter int W = 11
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   input wire logic run_i,
   input wire logic tick_i,
   input wire logic [W-1:0] ratio_i,
   output logic reload_o,
   output logic pulse_o
);
   localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1}; // decrement step
   logic [W-1:0] cnt_q; // ticks left before the next reload
   logic pulse_q; // one cycle output pulse
   logic at_end; // this tick reads the ratio latch

   assign at_end = (cnt_q == '0);
   // ratio latch is read on this cycle
   assign reload_o = run_i & tick_i & at_end;

   // while stopped the count is preset, so paired dividers restart in step
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_q <= '0;
         pulse_q <= 1'b0;
      end else if (clk_en_i) begin
         if (!run_i) begin
            cnt_q <= ratio_i - ONE;
            pulse_q <= 1'b0;
         end else if (tick_i && at_end) begin
            cnt_q <= ratio_i - ONE;
            pulse_q <= 1'b1;
         end else if (tick_i) begin
            cnt_q <= cnt_q - ONE;
            pulse_q <= 1'b0;
         end else begin
            pulse_q <= 1'b0;
         end
      end
   end

   assign pulse_o = pulse_q;
endmodule // dpsp_divider

// file: core/dpsp_top.sv
`timescale 1ns/1ps
// How it works
// R1 - clock edges ignored while enable high
// R2 - keep only last 21 bits, no count
// R3 - enable rising loads the addressed latch
// R4 - programming accepted even while loops off
// R5 - host keeps reference clock running
// R6 - host sends most significant bit first
// R7 - last four bits address, rest data
// R8 - only five address codes select latches
// R9 - enable rising edge makes one load pulse
// R10 - load pulse never meets divider reload
// R11 - host holds enable high long enough
// R12 - host raises enable after full word
// R13 - divider latches sized 17, 11, 14, 11
// R14 - host writes zero test bits
// R15 - software shutdown bits, one means off
// R16 - lock select chooses lock output source
// R17 - ratio bits pick pump ratio, halve normal
// R18 - shutdowns gate dividers and pumps, speedup
// R19 - effective shutdown is hardware or software
// R20 - restart main and reference dividers together
// R21 - second loop dividers 14 and 11 bits
// R22 - main feedback ratio spans 512 to 131071
// R23 - lock pulse lasts as long as error
// R24 - unknown address leaves latches unchanged
// R25 - data sampled on programming clock rise
module dpsp_top (
   input wire logic clk_i, // crystal reference clock
   input wire logic reset_i,
   input wire logic clk_en_i,
   input wire logic prog_enable_n_i, // programming enable pin
   input wire logic prog_clk_i, // programming clock pin
   input wire logic prog_data_i, // programming data pin
   input wire logic main_loop_hw_shutdown_i,
   input wire logic second_loop_hw_shutdown_i,
   input wire logic speedup_i, // fast mode request pin
   input wire logic main_vco_tick_i, // prescaled main vco
   input wire logic second_vco_tick_i, // prescaled second vco
   output logic main_normal_pump_up_o,
   output logic main_normal_pump_dn_o,
   output logic main_speedup_pump_up_o,
   output logic main_speedup_pump_dn_o,
   output logic second_loop_pump_up_o,
   output logic second_loop_pump_dn_o,
   output logic [1:0] pump_ratio_sel_o,
   output logic main_normal_pump_half_o,
   output logic main_dividers_on_o,
   output logic second_dividers_on_o,
   output logic lock_pin_o,
   output logic lock_pin_oe_n_o
);
   // ============================================================
   // pin synchronisation
   // ============================================================
   localparam int NPIN = 8; // number of synchronised pins
   logic [NPIN-1:0] pins_raw; // pins as they arrive
   logic [NPIN-1:0] pins_s; // pins after two flops
   logic en_act_s; // enable active, synchronised
   logic en_n_s; // enable level, idles high
   logic pclk_s; // programming clock, synchronised
   logic pdata_s; // data, synchronised
   logic hw_main_s; // main hardware shutdown
   logic hw_second_s; // second hardware shutdown
   logic fast_s; // speedup request
   logic mtick_s; // main vco tick level
   logic stick_s; // second vco tick level

   assign pins_raw = {~prog_enable_n_i, prog_clk_i, prog_data_i, main_loop_hw_shutdown_i,
                      second_loop_hw_shutdown_i, speedup_i, main_vco_tick_i, second_vco_tick_i};

   dpsp_sync #(.W(NPIN)) u_sync (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .clk_en_i(clk_en_i),
      .async_i(pins_raw),
      .sync_o(pins_s)
   );

   assign {en_act_s, pclk_s, pdata_s, hw_main_s, hw_second_s, fast_s, mtick_s, stick_s} = pins_s;
   // enable enters inverted: synchroniser reset level is idle, no false burst end
   assign en_n_s = ~en_act_s;

   // previous samples for edge detection
   logic en_n_prev_q;
   logic pclk_prev_q;
   logic mtick_prev_q;
   logic stick_prev_q;

   // edge history; enable idles high so no spurious load at release
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         en_n_prev_q <= 1'b1;
         pclk_prev_q <= 1'b0;
         mtick_prev_q <= 1'b0;
         stick_prev_q <= 1'b0;
      end else if (clk_en_i) begin
         en_n_prev_q <= en_n_s;
         pclk_prev_q <= pclk_s;
         mtick_prev_q <= mtick_s;
         stick_prev_q <= stick_s;
      end
   end

   logic pclk_rise; // programming clock rising
   logic en_rise; // burst end
   logic mtick; // one main vco tick
   logic stick; // one second vco tick
   assign pclk_rise = dpsp_pkg::rise(pclk_prev_q, pclk_s); // see R25
   assign en_rise = dpsp_pkg::rise(en_n_prev_q, en_n_s);
   assign mtick = dpsp_pkg::rise(mtick_prev_q, mtick_s);
   assign stick = dpsp_pkg::rise(stick_prev_q, stick_s);

   // ============================================================
   // shift register
   // ============================================================
   logic [dpsp_pkg::WORD_W-1:0] shift_q; // last bits clocked in
   logic shift_en; // capture this data bit
   logic [dpsp_pkg::ADDR_W-1:0] addr_field; // latch_addr_field
   logic [dpsp_pkg::DATA_W-1:0] data_field; // leading seventeen bits

   // edges outside a burst are dropped with their bit
   assign shift_en = pclk_rise & ~en_n_s; // see R1

   // older leading bits fall off the top, no pulse count kept
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         shift_q <= '0;
      end else if (clk_en_i && shift_en) begin
         shift_q <= {shift_q[dpsp_pkg::WORD_W-2:0], pdata_s}; // see R2
      end
   end

   // first bit in ends at the top, so trailing bits are the address
   assign addr_field = shift_q[dpsp_pkg::ADDR_LSB +: dpsp_pkg::ADDR_W]; // see R7
   assign data_field = shift_q[dpsp_pkg::DATA_LSB +: dpsp_pkg::DATA_W]; // see R7

   // ============================================================
   // load pulse scheduling
   // ============================================================
   logic load_pend_q; // burst ended, load not yet done
   logic any_reload; // some divider reads its latch now
   logic load_fire; // the single load pulse
   logic main_fb_rl, main_ref_rl, second_fb_rl, second_ref_rl;

   assign any_reload = main_fb_rl | main_ref_rl | second_fb_rl | second_ref_rl;
   // held back for as long as any divider is reloading
   assign load_fire = load_pend_q & ~any_reload; // see R10

   // the wait is short: reference dividers reload no more than every few cycles
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         load_pend_q <= 1'b0;
      end else if (clk_en_i) begin
         load_pend_q <= en_rise | (load_pend_q & ~load_fire); // see R9
      end
   end

   // ============================================================
   // latches
   // ============================================================
   logic [dpsp_pkg::DATA_W-1:0] ctrl_q; // control_test_word
   logic [dpsp_pkg::MAIN_FB_W-1:0] main_fb_q; // main_loop_fb_divider
   logic [dpsp_pkg::MAIN_REF_W-1:0] main_ref_q; // main_loop_ref_divider
   logic [dpsp_pkg::SECOND_FB_W-1:0] second_fb_q; // second_loop_fb_divider
   logic [dpsp_pkg::SECOND_REF_W-1:0] second_ref_q; // second_loop_ref_divider
   logic sel_ctrl, sel_main_fb, sel_main_ref, sel_second_fb, sel_second_ref;

   // five codes decode; the other eleven select nothing
   assign sel_ctrl = load_fire & (addr_field == dpsp_pkg::ADDR_CTRL); // see R8 see R24
   assign sel_main_fb = load_fire & (addr_field == dpsp_pkg::ADDR_MAIN_FB);
   assign sel_main_ref = load_fire & (addr_field == dpsp_pkg::ADDR_MAIN_REF);
   assign sel_second_fb = load_fire & (addr_field == dpsp_pkg::ADDR_SECOND_FB);
   assign sel_second_ref = load_fire & (addr_field == dpsp_pkg::ADDR_SECOND_REF);

   // writes are never gated by shutdown; upper pad bits are dropped
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ctrl_q <= dpsp_pkg::CTRL_RESET;
         main_fb_q <= dpsp_pkg::MAIN_FB_RESET;
         main_ref_q <= dpsp_pkg::MAIN_REF_RESET;
         second_fb_q <= dpsp_pkg::SECOND_FB_RESET;
         second_ref_q <= dpsp_pkg::SECOND_REF_RESET;
      end else if (clk_en_i) begin
         if (sel_ctrl) ctrl_q <= data_field; // see R3 see R4
         if (sel_main_fb) main_fb_q <= data_field[dpsp_pkg::MAIN_FB_W-1:0]; // see R13
         if (sel_main_ref) main_ref_q <= data_field[dpsp_pkg::MAIN_REF_W-1:0]; // see R13
         if (sel_second_fb) second_fb_q <= data_field[dpsp_pkg::SECOND_FB_W-1:0]; // see R21
         if (sel_second_ref) second_ref_q <= data_field[dpsp_pkg::SECOND_REF_W-1:0];
      end
   end

   // ============================================================
   // power control
   // ============================================================
   logic main_off; // effective main shutdown
   logic second_off; // effective second shutdown
   dpsp_pkg::dpsp_lock_sel_t lock_sel; // lock output source
   logic [1:0] ratio_sel; // pump ratio bits

   // either hardware pin or software bit switches a loop off
   assign main_off = hw_main_s | ctrl_q[dpsp_pkg::CTL_SW_MAIN]; // see R19 see R15
   assign second_off = hw_second_s | ctrl_q[dpsp_pkg::CTL_SW_SECOND]; // see R19 see R15
   assign lock_sel = dpsp_pkg::dpsp_lock_sel_t'({ctrl_q[dpsp_pkg::CTL_LOCK_MAIN],
                                                 ctrl_q[dpsp_pkg::CTL_LOCK_SECOND]});
   assign ratio_sel = {ctrl_q[dpsp_pkg::CTL_RATIO_HI], ctrl_q[dpsp_pkg::CTL_RATIO_LO]};

   // ============================================================
   // dividers
   // ============================================================
   logic main_fb_p, main_ref_p, second_fb_p, second_ref_p; // divider outputs

   // main pair shares one run signal, so both leave shutdown together
   dpsp_divider #(.W(dpsp_pkg::MAIN_FB_W)) u_main_fb ( // see R20 see R22
      .clk_i(clk_i),
      .reset_i(reset_i),
      .clk_en_i(clk_en_i),
      .run_i(~main_off),
      .tick_i(mtick),
      .ratio_i(main_fb_q),
      .reload_o(main_fb_rl),
      .pulse_o(main_fb_p)
   );

   dpsp_divider #(.W(dpsp_pkg::MAIN_REF_W)) u_main_ref (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .clk_en_i(clk_en_i),
      .run_i(~main_off),
      .tick_i(1'b1),
      .ratio_i(main_ref_q),
      .reload_o(main_ref_rl),
      .pulse_o(main_ref_p)
   );

   dpsp_divider #(.W(dpsp_pkg::SECOND_FB_W)) u_second_fb ( // see R20
      .clk_i(clk_i),
      .reset_i(reset_i),
      .clk_en_i(clk_en_i),
      .run_i(~second_off),
      .tick_i(stick),
      .ratio_i(second_fb_q),
      .reload_o(second_fb_rl),
      .pulse_o(second_fb_p)
   );

   dpsp_divider #(.W(dpsp_pkg::SECOND_REF_W)) u_second_ref (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .clk_en_i(clk_en_i),
      .run_i(~second_off),
      .tick_i(1'b1),
      .ratio_i(second_ref_q),
      .reload_o(second_ref_rl),
      .pulse_o(second_ref_p)
   );

   // ============================================================
   // phase detectors and outputs
   // ============================================================
   // up while reference leads, down while feedback leads, clear when both seen
   function automatic logic [1:0] pfd_next(input logic up, input logic dn,
                                           input logic ref_p, input logic fb_p,
                                           input logic off);
      logic nu;
      logic nd;
      nu = up | ref_p;
      nd = dn | fb_p;
      if (off || (nu && nd)) begin
         pfd_next = 2'b00;
      end else begin
         pfd_next = {nu, nd};
      end
   endfunction

   logic main_up_q, main_dn_q, second_up_q, second_dn_q; // detector state
   logic main_err, second_err, lock_err; // phase error levels
   logic fast_on; // speedup pump allowed
   logic [1:0] main_pfd_d, second_pfd_d;

   assign main_pfd_d = pfd_next(main_up_q, main_dn_q, main_ref_p, main_fb_p, main_off);
   assign second_pfd_d = pfd_next(second_up_q, second_dn_q, second_ref_p, second_fb_p,
                                  second_off);
   assign main_err = main_up_q | main_dn_q;
   assign second_err = second_up_q | second_dn_q;
   assign fast_on = ~main_off & fast_s; // see R18
   // error source picked by the lock select field
   assign lock_err = (lock_sel == dpsp_pkg::LOCK_SECOND) ? second_err : // see R16
                     (lock_sel == dpsp_pkg::LOCK_MAIN) ? main_err :
                     (lock_sel == dpsp_pkg::LOCK_BOTH) ? (main_err | second_err) : 1'b0;

   // detector state
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         {main_up_q, main_dn_q} <= 2'b00;
         {second_up_q, second_dn_q} <= 2'b00;
      end else if (clk_en_i) begin
         {main_up_q, main_dn_q} <= main_pfd_d;
         {second_up_q, second_dn_q} <= second_pfd_d;
      end
   end

   // registered pin outputs, one cycle behind the detector
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         main_normal_pump_up_o <= 1'b0;
         main_normal_pump_dn_o <= 1'b0;
         main_speedup_pump_up_o <= 1'b0;
         main_speedup_pump_dn_o <= 1'b0;
         second_loop_pump_up_o <= 1'b0;
         second_loop_pump_dn_o <= 1'b0;
         pump_ratio_sel_o <= 2'b00;
         main_normal_pump_half_o <= 1'b0;
         main_dividers_on_o <= 1'b0;
         second_dividers_on_o <= 1'b0;
         lock_pin_oe_n_o <= 1'b1;
         lock_pin_o <= 1'b0;
      end else if (clk_en_i) begin
         main_normal_pump_up_o <= main_up_q & ~main_off; // see R18
         main_normal_pump_dn_o <= main_dn_q & ~main_off;
         main_speedup_pump_up_o <= main_up_q & fast_on; // see R18
         main_speedup_pump_dn_o <= main_dn_q & fast_on;
         second_loop_pump_up_o <= second_up_q & ~second_off; // see R18
         second_loop_pump_dn_o <= second_dn_q & ~second_off;
         pump_ratio_sel_o <= ratio_sel; // see R17
         main_normal_pump_half_o <= ratio_sel[1]; // see R17
         main_dividers_on_o <= ~main_off;
         second_dividers_on_o <= ~second_off;
         lock_pin_oe_n_o <= ~lock_err; // see R23
         lock_pin_o <= 1'b0; // open drain, only ever sinks
      end
   end

   // ============================================================
   // checks
   // ============================================================
   a_shift_ignored: assert property (@(posedge clk_i) disable iff (reset_i) // see R1
      (clk_en_i && en_n_s) |=> $stable(shift_q))
      else $error("shift register moved while enable high");

   a_shift_keeps: assert property (@(posedge clk_i) disable iff (reset_i) // see R2
      (clk_en_i && shift_en) |=> shift_q == {$past(shift_q[dpsp_pkg::WORD_W-2:0]), $past(pdata_s)})
      else $error("shift register did not take the new bit");

   a_load_ctrl: assert property (@(posedge clk_i) disable iff (reset_i) // see R3
      (clk_en_i && load_fire && addr_field == dpsp_pkg::ADDR_CTRL)
         |=> ctrl_q == $past(data_field))
      else $error("control latch not loaded");

   a_unknown_addr: assert property (@(posedge clk_i) disable iff (reset_i) // see R24
      (load_fire && addr_field > dpsp_pkg::ADDR_SECOND_REF) |=> $stable(ctrl_q)
         && $stable(main_fb_q) && $stable(main_ref_q) && $stable(second_fb_q)
         && $stable(second_ref_q))
      else $error("unmapped address changed a latch");

   a_no_clash: assert property (@(posedge clk_i) disable iff (reset_i) // see R10
      (clk_en_i && any_reload) |=> $stable(ctrl_q) && $stable(main_fb_q)
         && $stable(main_ref_q) && $stable(second_fb_q) && $stable(second_ref_q))
      else $error("load pulse met a divider reload");

   a_load_single: assert property (@(posedge clk_i) disable iff (reset_i) // see R9
      (clk_en_i && en_rise) |-> ##[1:4] (load_fire && clk_en_i) || !clk_en_i)
      else $error("no load pulse after enable rise");

   a_off_merge: assert property (@(posedge clk_i) disable iff (reset_i) // see R19
      clk_en_i |=> main_dividers_on_o == !$past(hw_main_s || ctrl_q[dpsp_pkg::CTL_SW_MAIN]))
      else $error("main divider state not or of shutdowns");

   a_speedup_gate: assert property (@(posedge clk_i) disable iff (reset_i) // see R18
      (clk_en_i && (main_off || !fast_s)) |=> !main_speedup_pump_up_o
         && !main_speedup_pump_dn_o)
      else $error("speedup pump active while not allowed");

   a_lock_both: assert property (@(posedge clk_i) disable iff (reset_i) // see R16
      (clk_en_i && ctrl_q[dpsp_pkg::CTL_LOCK_MAIN] && ctrl_q[dpsp_pkg::CTL_LOCK_SECOND])
         |=> lock_pin_oe_n_o == !$past(main_err || second_err))
      else $error("lock output not or of both errors");

   a_ratio_half: assert property (@(posedge clk_i) disable iff (reset_i) // see R17
      clk_en_i |=> main_normal_pump_half_o == $past(ctrl_q[dpsp_pkg::CTL_RATIO_HI]))
      else $error("normal pump half not following ratio bit");
endmodule // dpsp_top

// file: tb/dpsp_host.sv
`timescale 1ns/1ps
// ============================================================
// host side of the three wire programming bus
// ============================================================
module dpsp_host (
   input wire logic clk_i,
   output logic enable_n_o,
   output logic sclk_o,
   output logic sdata_o
);
   initial begin
      enable_n_o = 1'b1; // bus idle
      sclk_o = 1'b0; // clock starts low; only unframed sends pulse it outside frames
      sdata_o = 1'b0;
   end
   // hold pin levels long enough for the two flop synchronisers
   task automatic hold();
      repeat (5) @(negedge clk_i);
   endtask
   // n bits of w, msb first; unframed when frame is clear
   task automatic send(input logic [24:0] w, input int n, input bit frame);
      if (frame) enable_n_o = 1'b0; // held low for the whole word
      hold();
      for (int i = n - 1; i >= 0; i--) begin
         sdata_o = w[i];
         hold();
         sclk_o = 1'b1;
         hold();
         sclk_o = 1'b0;
      end
      hold();
      enable_n_o = 1'b1; // long high gap after load
      sdata_o = ~sdata_o; // released line shows no stale bit
      repeat (12) @(negedge clk_i);
   endtask
endmodule // dpsp_host

// file: tb/dual_pll_serial_program_port_bench.sv
`timescale 1ns/1ps
// ============================================================
// bench for the serial programming port
// ============================================================
module dual_pll_serial_program_port_bench;
   logic clk = 1'b0; // reference clock runs throughout
   logic rst = 1'b1;
   logic hw_m = 1'b0; // hardware shutdown pins
   logic hw_s = 1'b0;
   logic fast = 1'b0; // speedup request pin
   logic en_n, sck, sda, on_m, on_s, half, oe_n, np_up, sp_up, s2_up;
   logic [1:0] ratio;
   int cyc = 0;
   int mismatches = 0;
   int n_checks = 0;
   always #2.5 clk = ~clk;
   dpsp_host host (.clk_i(clk), .enable_n_o(en_n), .sclk_o(sck), .sdata_o(sda));
   dpsp_top uut (.clk_i(clk), .reset_i(rst), .clk_en_i(1'b1), .prog_enable_n_i(en_n),
      .prog_clk_i(sck), .prog_data_i(sda), .main_loop_hw_shutdown_i(hw_m),
      .second_loop_hw_shutdown_i(hw_s), .speedup_i(fast), .main_vco_tick_i(cyc[2]),
      .second_vco_tick_i(cyc[3]), .main_normal_pump_up_o(np_up), .main_normal_pump_dn_o(),
      .main_speedup_pump_up_o(sp_up), .main_speedup_pump_dn_o(), .second_loop_pump_up_o(s2_up),
      .second_loop_pump_dn_o(), .pump_ratio_sel_o(ratio), .main_normal_pump_half_o(half),
      .main_dividers_on_o(on_m), .second_dividers_on_o(on_s), .lock_pin_o(),
      .lock_pin_oe_n_o(oe_n));
   // ============================================================
   // helpers
   // ============================================================
   task automatic check(input string what, input logic [3:0] got, input logic [3:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // control word: ratio, sw shutdowns, address
   function automatic logic [24:0] ctl(input logic [1:0] r, input logic m, input logic s,
      input logic [3:0] a);
      logic [16:0] d;
      d = 17'h00000; // test bits stay zero
      d[dpsp_pkg::CTL_RATIO_HI] = r[1];
      d[dpsp_pkg::CTL_RATIO_LO] = r[0];
      d[dpsp_pkg::CTL_SW_MAIN] = m;
      d[dpsp_pkg::CTL_SW_SECOND] = s;
      return {4'h0, d, a};
   endfunction
   task automatic settle();
      repeat (10) @(negedge clk);
   endtask
   task automatic t_reset();
      check("ons", {on_m, on_s}, 4'h0);
      check("ratio", {half, ratio}, 4'h0);
      check("lock", oe_n, 4'h1);
   endtask
   // every ratio code, sent with four junk leading bits
   task automatic t_ratio();
      for (int r = 0; r < 4; r++) begin
         host.send(25'h1e00000 | ctl(r[1:0], 1'b0, 1'b0, dpsp_pkg::ADDR_CTRL), 25, 1'b1);
         check("ratio", {half, ratio}, {1'b0, r[1], r[1:0]});
         check("ons", {on_m, on_s}, 4'h3);
      end
   endtask
   task automatic t_shut();
      hw_m = 1'b1;
      settle();
      check("ons", {on_m, on_s}, 4'h1);
      hw_s = 1'b1;
      settle();
      check("ons", {on_m, on_s}, 4'h0);
      host.send(ctl(2'b01, 1'b0, 1'b0, dpsp_pkg::ADDR_CTRL), 21, 1'b1);
      check("ratio", ratio, 4'h1);
      hw_m = 1'b0;
      hw_s = 1'b0;
      settle();
      check("ons", {on_m, on_s}, 4'h3);
      host.send(ctl(2'b01, 1'b1, 1'b0, dpsp_pkg::ADDR_CTRL), 21, 1'b1);
      check("ons", {on_m, on_s}, 4'h1);
      host.send(ctl(2'b01, 1'b0, 1'b0, dpsp_pkg::ADDR_CTRL), 21, 1'b1);
   endtask
   // unused codes change nothing
   task automatic t_addr();
      for (int a = 5; a < 16; a++) begin
         host.send(ctl(2'b10, 1'b1, 1'b1, a[3:0]), 21, 1'b1);
         check("ctrl", {on_m, on_s, ratio}, 4'hd);
      end
   endtask
   // clocks with enable high must not reach the shift register
   task automatic t_edge();
      host.send(ctl(2'b11, 1'b0, 1'b0, dpsp_pkg::ADDR_CTRL), 21, 1'b0);
      host.send(25'h0000000, 0, 1'b1);
      check("ctrl", {on_m, on_s, ratio}, 4'hd);
   endtask
   // pumps and lock pin follow the detectors; speedup only on request
   task automatic t_fast();
      logic [3:0] seen;
      host.send(25'h0060000 | ctl(2'b01, 1'b0, 1'b0, dpsp_pkg::ADDR_CTRL), 21, 1'b1);
      for (int f = 1; f >= 0; f--) begin
         fast = f[0];
         settle();
         seen = 4'h0;
         repeat (24) begin
            @(negedge clk);
            seen = seen | {sp_up, np_up, s2_up, ~oe_n};
         end
         check("pumps", seen, {f[0], 3'h7});
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // watchdog against a hung run
   always @(negedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         final_report();
      end
   end
   initial begin
      repeat (8) @(negedge clk);
      rst = 1'b0;
      settle();
      t_reset();
      t_ratio();
      t_shut();
      t_addr();
      t_edge();
      t_fast();
      final_report();
   end
endmodule // dual_pll_serial_program_port_bench
